// ==== idr_bank.sv ====
// top of the i/o range decode configuration bank
// assumes: config cycles and i/o requests arrive on core_clk, one per strobe
//
// Overview of operation
// - bus controller window decodes only when enabled
// - bus controller base bits 15:6, 64 bytes
// - pin block window decodes only when enabled
// - pin block base bits 15:6, 64 bytes
// - power event window decodes only when enabled
// - power event base bits 15:4, low reserved
// - general event window decodes only when enabled
// - general event base bits 15:6, 64 bytes
// - bits 18, 17 gate output clocks, default on
// - registers reached by configuration read and write
`timescale 1ns/1ps
`default_nettype none
`include "idr_cfg.svh"

module idr_bank (
   input  wire logic                       core_clk,
   input  wire logic                       srst,
   input  wire logic                       ce,
   input  wire logic                       cfg_req,
   input  wire logic                       cfg_we,
   input  wire logic [7:0]                 cfg_addr,
   input  wire logic [3:0]                 cfg_be,
   input  wire idr_pkg::idr_word_t         cfg_wdata,
   output idr_pkg::idr_word_t              cfg_rdata_q,
   output logic                            cfg_ack_q,
   input  wire logic                       io_req,
   input  wire logic [`IDR_IO_AW-1:0]      io_addr,
   output logic [`IDR_NUM_WIN-1:0]         io_hit_q,
   output logic                            clk1_en_q,
   output logic                            clk2_en_q
);

   idr_pkg::idr_word_t  base_q [`IDR_NUM_WIN];
   idr_pkg::idr_word_t  pctl_q;
   idr_pkg::idr_word_t  rdata_d;
   logic [7:0]          word_addr;
   logic                wr_stb;
   logic [`IDR_NUM_WIN-1:0] base_wr;
   // a macro literal cannot be bit-selected, so name the reset image
   localparam idr_pkg::idr_word_t CLK_RST = `IDR_CLK_RST;

   // config cycles address whole dwords; byte lanes pick the bytes
   assign word_addr = {cfg_addr[7:2], 2'b00};
   assign wr_stb    = cfg_req && cfg_we;

   always_comb begin
      base_wr = '0;
      case (word_addr)
         `IDR_OFF_BUS: begin
            base_wr[idr_pkg::IDR_WIN_BUS] = wr_stb;
         end
         `IDR_OFF_PIN: begin
            base_wr[idr_pkg::IDR_WIN_PIN] = wr_stb;
         end
         `IDR_OFF_PWR: begin
            base_wr[idr_pkg::IDR_WIN_PWR] = wr_stb;
         end
         `IDR_OFF_GPE: begin
            base_wr[idr_pkg::IDR_WIN_GPE] = wr_stb;
         end
         default: begin
            base_wr = '0;
         end
      endcase
   end

   // one base register and one claim decoder per window
   genvar gi;
   generate
      for (gi = 0; gi < `IDR_NUM_WIN; gi++) begin : g_win
         // the power event block is the only 16-byte window
         localparam int LSB = (gi == idr_pkg::IDR_WIN_PWR) ?
                              `IDR_LSB_PWR : `IDR_LSB_WIDE;

         idr_base_reg #(
            .LSB      (LSB)
         ) u_base (
            .core_clk (core_clk),
            .srst     (srst),
            .ce       (ce),
            .wr       (base_wr[gi]),
            .be       (cfg_be),
            .wdata    (cfg_wdata),
            .base_q   (base_q[gi])
         );

         idr_win_dec #(
            .LSB      (LSB)
         ) u_dec (
            .core_clk (core_clk),
            .srst     (srst),
            .ce       (ce),
            .io_req   (io_req),
            .io_addr  (io_addr),
            .base_q   (base_q[gi]),
            .hit_q    (io_hit_q[gi])
         );
      end
   endgenerate

   // output clock gates; only bits 18 and 17 are stored
   always_ff @(posedge core_clk) begin
      if (srst) begin
         clk2_en_q <= CLK_RST[`IDR_CLK2_BIT];
         clk1_en_q <= CLK_RST[`IDR_CLK1_BIT];
      end else if (ce && wr_stb && word_addr == `IDR_OFF_CLK && cfg_be[2]) begin
         clk2_en_q <= cfg_wdata[`IDR_CLK2_BIT];
         clk1_en_q <= cfg_wdata[`IDR_CLK1_BIT];
      end
   end

   // field layout unknown here, so kept as plain storage per byte lane
   always_ff @(posedge core_clk) begin
      if (srst) begin
         pctl_q <= `IDR_PCTL_RST;
      end else if (ce && wr_stb && word_addr == `IDR_OFF_PCTL) begin
         for (int b = 0; b < 4; b++) begin
            if (cfg_be[b]) begin
               pctl_q[b*8 +: 8] <= cfg_wdata[b*8 +: 8];
            end
         end
      end
   end

   // read mux; unmapped offsets read zero
   always_comb begin
      rdata_d = '0;
      case (word_addr)
         `IDR_OFF_BUS: begin
            rdata_d = base_q[idr_pkg::IDR_WIN_BUS];
         end
         `IDR_OFF_PIN: begin
            rdata_d = base_q[idr_pkg::IDR_WIN_PIN];
         end
         `IDR_OFF_PWR: begin
            rdata_d = base_q[idr_pkg::IDR_WIN_PWR];
         end
         `IDR_OFF_GPE: begin
            rdata_d = base_q[idr_pkg::IDR_WIN_GPE];
         end
         `IDR_OFF_CLK: begin
            rdata_d[`IDR_CLK2_BIT] = clk2_en_q;
            rdata_d[`IDR_CLK1_BIT] = clk1_en_q;
         end
         `IDR_OFF_PCTL: begin
            rdata_d = pctl_q;
         end
         default: begin
            rdata_d = '0;
         end
      endcase
   end

   // every cycle seen with ce high is answered one edge later; writes answer with zero data
   always_ff @(posedge core_clk) begin
      if (srst) begin
         cfg_ack_q <= 1'b0;
      end else if (ce) begin
         cfg_ack_q <= cfg_req;
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         cfg_rdata_q <= '0;
      end else if (ce) begin
         cfg_rdata_q <= (cfg_req && !cfg_we) ? rdata_d : '0;
      end
   end

   // checks
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (srst);

   a_bus_en_gate: assert property (
      ce && !base_q[idr_pkg::IDR_WIN_BUS][`IDR_EN_BIT]
      |=> !io_hit_q[idr_pkg::IDR_WIN_BUS]
   ) else $error("bus window claimed while disabled");

   a_bus_base_hit: assert property (
      ce && io_req && base_q[idr_pkg::IDR_WIN_BUS][`IDR_EN_BIT] &&
      io_addr[15:6] == base_q[idr_pkg::IDR_WIN_BUS][15:6]
      |=> io_hit_q[idr_pkg::IDR_WIN_BUS]
   ) else $error("bus window missed a matching access");

   a_bus_mismatch: assert property (
      ce && io_req &&
      io_addr[15:6] != base_q[idr_pkg::IDR_WIN_BUS][15:6]
      |=> !io_hit_q[idr_pkg::IDR_WIN_BUS]
   ) else $error("bus window claimed a foreign address");

   a_pin_en_gate: assert property (
      io_hit_q[idr_pkg::IDR_WIN_PIN]
      |-> $past(base_q[idr_pkg::IDR_WIN_PIN][`IDR_EN_BIT]) || !$past(ce)
   ) else $error("pin window claimed while disabled");

   a_pin_base_hit: assert property (
      ce && io_req && base_q[idr_pkg::IDR_WIN_PIN][`IDR_EN_BIT] &&
      io_addr[15:6] == base_q[idr_pkg::IDR_WIN_PIN][15:6]
      |=> io_hit_q[idr_pkg::IDR_WIN_PIN]
   ) else $error("pin window missed a matching access");

   a_pin_mismatch: assert property (
      ce && io_req &&
      io_addr[15:6] != base_q[idr_pkg::IDR_WIN_PIN][15:6]
      |=> !io_hit_q[idr_pkg::IDR_WIN_PIN]
   ) else $error("pin window claimed a foreign address");

   a_pwr_en_gate: assert property (
      ce && !base_q[idr_pkg::IDR_WIN_PWR][`IDR_EN_BIT]
      |=> !io_hit_q[idr_pkg::IDR_WIN_PWR]
   ) else $error("power window claimed while disabled");

   a_pwr_rsvd_low: assert property (
      base_q[idr_pkg::IDR_WIN_PWR][3:0] == 4'h0 &&
      base_q[idr_pkg::IDR_WIN_PWR][30:16] == 15'h0000
   ) else $error("power window reserved bits not zero");

   a_pwr_16_hit: assert property (
      ce && io_req && base_q[idr_pkg::IDR_WIN_PWR][`IDR_EN_BIT] &&
      io_addr[15:4] == base_q[idr_pkg::IDR_WIN_PWR][15:4]
      |=> io_hit_q[idr_pkg::IDR_WIN_PWR]
   ) else $error("power window missed a matching access");

   // the narrow window must not spill into the next 16 bytes
   a_pwr_mismatch: assert property (
      ce && io_req &&
      io_addr[15:4] != base_q[idr_pkg::IDR_WIN_PWR][15:4]
      |=> !io_hit_q[idr_pkg::IDR_WIN_PWR]
   ) else $error("power window claimed a foreign address");

   a_gpe_en_gate: assert property (
      ce && !base_q[idr_pkg::IDR_WIN_GPE][`IDR_EN_BIT]
      |=> !io_hit_q[idr_pkg::IDR_WIN_GPE]
   ) else $error("event window claimed while disabled");

   a_gpe_base_hit: assert property (
      ce && io_req && base_q[idr_pkg::IDR_WIN_GPE][`IDR_EN_BIT] &&
      io_addr[15:6] == base_q[idr_pkg::IDR_WIN_GPE][15:6]
      |=> io_hit_q[idr_pkg::IDR_WIN_GPE]
   ) else $error("event window missed a matching access");

   a_gpe_mismatch: assert property (
      ce && io_req &&
      io_addr[15:6] != base_q[idr_pkg::IDR_WIN_GPE][15:6]
      |=> !io_hit_q[idr_pkg::IDR_WIN_GPE]
   ) else $error("event window claimed a foreign address");

   a_clk_gate_wr: assert property (
      ce && wr_stb && word_addr == `IDR_OFF_CLK && cfg_be[2]
      |=> {clk2_en_q, clk1_en_q} ==
          $past({cfg_wdata[`IDR_CLK2_BIT], cfg_wdata[`IDR_CLK1_BIT]})
   ) else $error("clock gate bits not written");

   // a stray gate change would stop an output clock mid transfer
   a_clk_gate_hold: assert property (
      !(ce && wr_stb && word_addr == `IDR_OFF_CLK && cfg_be[2])
      |=> $stable({clk2_en_q, clk1_en_q})
   ) else $error("clock gate bits moved without a write");

   a_cfg_ack_one: assert property (
      ce && cfg_req |=> cfg_ack_q ##1
      (!cfg_ack_q || $past(cfg_req) || !$past(ce))
   ) else $error("config cycle not answered in one cycle");

   a_ack_idle_low: assert property (
      ce && !cfg_req |=> !cfg_ack_q
   ) else $error("answer without a config cycle");

   a_wr_rdata_zero: assert property (
      ce && cfg_req && cfg_we |=> cfg_rdata_q == '0
   ) else $error("write answered with nonzero data");

   // a low enable must leave every registered answer untouched
   a_ce_freeze: assert property (
      !ce |=> $stable(cfg_ack_q) && $stable(cfg_rdata_q) &&
      $stable(io_hit_q)
   ) else $error("registered outputs moved while enable low");

   a_bus_rsvd_read: assert property (
      ce && cfg_req && !cfg_we && word_addr == `IDR_OFF_BUS
      |=> cfg_rdata_q[30:16] == 15'h0000 && cfg_rdata_q[5:0] == 6'h00
   ) else $error("reserved bits read nonzero");

   a_clk_rsvd_read: assert property (
      ce && cfg_req && !cfg_we && word_addr == `IDR_OFF_CLK
      |=> cfg_rdata_q[31:19] == 13'h0 && cfg_rdata_q[16:0] == 17'h0
   ) else $error("clock register reserved bits read nonzero");

   a_unmapped_zero: assert property (
      ce && cfg_req && !(word_addr inside {`IDR_OFF_BUS, `IDR_OFF_PIN,
         `IDR_OFF_PWR, `IDR_OFF_GPE, `IDR_OFF_CLK, `IDR_OFF_PCTL})
      |=> cfg_rdata_q == '0
   ) else $error("unmapped offset read nonzero");

endmodule
`default_nettype wire

// ==== idr_cfg.svh ====
// constants for the i/o range decode configuration bank
// assumes: included by bare name from the package and the design modules
`ifndef IDR_CFG_SVH
`define IDR_CFG_SVH

// register offsets, byte addresses in configuration space
`define IDR_OFF_BUS      8'h40
`define IDR_OFF_PIN      8'h44
`define IDR_OFF_PWR      8'h48
`define IDR_OFF_GPE      8'h4c
`define IDR_OFF_CLK      8'h54
`define IDR_OFF_PCTL     8'h58

// field positions
`define IDR_EN_BIT       31
`define IDR_BASE_MSB     15
`define IDR_LSB_WIDE     6
`define IDR_LSB_PWR      4
`define IDR_CLK2_BIT     18
`define IDR_CLK1_BIT     17

// reset values
`define IDR_BASE_RST     32'h0000_0000
`define IDR_CLK_RST      32'h0006_0000
`define IDR_PCTL_RST     32'h0000_0001

// geometry
`define IDR_NUM_WIN      4
`define IDR_IO_AW        16

`endif

// ==== idr_pkg.sv ====
// types shared by the i/o range decode configuration bank
// assumes: idr_cfg.svh is on the include path
`include "idr_cfg.svh"

package idr_pkg;

   typedef logic [31:0] idr_word_t;

   // order gives the bit position of each window's claim output
   typedef enum {
      IDR_WIN_BUS,
      IDR_WIN_PIN,
      IDR_WIN_PWR,
      IDR_WIN_GPE
   } idr_win_t;

endpackage

// ==== idr_base_reg.sv ====
// one window base register: enable bit and base field, rest reads zero
// assumes: wr is a one-cycle write strobe already decoded for this offset
`timescale 1ns/1ps
`default_nettype none
`include "idr_cfg.svh"

module idr_base_reg #(
   parameter int LSB = `IDR_LSB_WIDE
) (
   input  wire logic                core_clk,
   input  wire logic                srst,
   input  wire logic                ce,
   input  wire logic                wr,
   input  wire logic [3:0]          be,
   input  wire idr_pkg::idr_word_t  wdata,
   output idr_pkg::idr_word_t       base_q
);

   // bits outside the mask are only ever loaded by reset, so they stay zero
   always_ff @(posedge core_clk) begin
      if (srst) begin
         base_q <= `IDR_BASE_RST;
      end else if (ce && wr) begin
         if (be[3]) begin
            base_q[`IDR_EN_BIT] <= wdata[`IDR_EN_BIT];
         end
         if (be[1]) begin
            base_q[`IDR_BASE_MSB:8] <= wdata[`IDR_BASE_MSB:8];
         end
         if (be[0]) begin
            base_q[7:LSB] <= wdata[7:LSB];
         end
      end
   end

endmodule
`default_nettype wire

// ==== idr_win_dec.sv ====
// claim logic for one i/o window, registered one cycle after the request
// assumes: io_req and io_addr come from logic on core_clk
`timescale 1ns/1ps
`default_nettype none
`include "idr_cfg.svh"

module idr_win_dec #(
   parameter int LSB = `IDR_LSB_WIDE
) (
   input  wire logic                       core_clk,
   input  wire logic                       srst,
   input  wire logic                       ce,
   input  wire logic                       io_req,
   input  wire logic [`IDR_IO_AW-1:0]      io_addr,
   input  wire idr_pkg::idr_word_t         base_q,
   output logic                            hit_q
);

   logic hit_d;

   // address bits below the window size are ignored
   always_comb begin
      hit_d = io_req && base_q[`IDR_EN_BIT] &&
              (io_addr[`IDR_BASE_MSB:LSB] == base_q[`IDR_BASE_MSB:LSB]);
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         hit_q <= 1'b0;
      end else if (ce) begin
         hit_q <= hit_d;
      end
   end

endmodule
`default_nettype wire

// ==== tb_top.sv ====
// self-checking bench for the i/o range decode configuration bank
// assumes: idr_pkg compiled first; ce high except in its own test
`timescale 1ns/1ps
`default_nettype none

module tb_top;
   localparam idr_pkg::idr_word_t WIDE_MASK = 32'h8000_ffc0;
   localparam idr_pkg::idr_word_t PWR_MASK  = 32'h8000_fff0;
   localparam logic [7:0]  OFFS [4] = '{8'h40, 8'h44, 8'h48, 8'h4c};
   // power at 0x2ff0, general event 16 above it, 64-byte aligned
   localparam idr_pkg::idr_word_t BASES [4] = '{32'h8000_1000,
      32'h8000_2040, 32'h8000_2ff0, 32'h8000_3000};
   localparam logic [15:0] IO_A [12] = '{16'h1000, 16'h103f, 16'h1040,
      16'h2040, 16'h207f, 16'h2080, 16'h2fef, 16'h2ff0, 16'h2fff,
      16'h3000, 16'h303f, 16'h3040};
   localparam logic [3:0]  IO_E [12] = '{4'h1, 4'h1, 4'h0, 4'h2, 4'h2,
      4'h0, 4'h0, 4'h4, 4'h4, 4'h8, 4'h8, 4'h0};

   logic               core_clk  = 1'b0;
   logic               srst      = 1'b1;
   logic               ce        = 1'b1;
   logic               cfg_req   = 1'b0;
   logic               cfg_we    = 1'b0;
   logic [7:0]         cfg_addr  = 8'h00;
   logic [3:0]         cfg_be    = 4'h0;
   idr_pkg::idr_word_t cfg_wdata = 32'h0000_0000;
   idr_pkg::idr_word_t cfg_rdata_q;
   logic               cfg_ack_q;
   logic               io_req    = 1'b0;
   logic [15:0]        io_addr   = 16'h0000;
   logic [3:0]         io_hit_q;
   logic               clk1_en_q;
   logic               clk2_en_q;
   int                 fail_count  = 0;
   int                 check_count = 0;

   always #10 core_clk = ~core_clk;

   idr_bank idr_bank_i (
      .core_clk    (core_clk),
      .srst        (srst),
      .ce          (ce),
      .cfg_req     (cfg_req),
      .cfg_we      (cfg_we),
      .cfg_addr    (cfg_addr),
      .cfg_be      (cfg_be),
      .cfg_wdata   (cfg_wdata),
      .cfg_rdata_q (cfg_rdata_q),
      .cfg_ack_q   (cfg_ack_q),
      .io_req      (io_req),
      .io_addr     (io_addr),
      .io_hit_q    (io_hit_q),
      .clk1_en_q   (clk1_en_q),
      .clk2_en_q   (clk2_en_q)
   );

   task automatic chk(input idr_pkg::idr_word_t seen,
                      input idr_pkg::idr_word_t exp);
      check_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   // one config cycle; ack and read data come one edge later
   task automatic cfg_acc(input logic we, input logic [7:0] a,
                          input logic [3:0] be, input idr_pkg::idr_word_t d,
                          input idr_pkg::idr_word_t exp);
      @(posedge core_clk);
      cfg_req   <= 1'b1;
      cfg_we    <= we;
      cfg_addr  <= a;
      cfg_be    <= be;
      cfg_wdata <= d;
      @(posedge core_clk);
      cfg_req   <= 1'b0;
      #1;
      chk({31'h0, cfg_ack_q}, 32'h1);
      chk(cfg_rdata_q, exp);
   endtask

   task automatic io_chk(input logic [15:0] a, input logic [3:0] exp);
      @(posedge core_clk);
      io_req  <= 1'b1;
      io_addr <= a;
      @(posedge core_clk);
      io_req  <= 1'b0;
      #1;
      chk({28'h0, io_hit_q}, {28'h0, exp});
   endtask

   task automatic complete_run;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // tests need some 130 cycles; stop well beyond that
   initial begin
      #50000;
      fail_count++;
      complete_run;
   end

   initial begin
      repeat (6) @(posedge core_clk);
      srst <= 1'b0;
      for (int i = 0; i < 4; i++) cfg_acc(0, OFFS[i], 4'hf, 0, 0);
      cfg_acc(0, 8'h54, 4'hf, 0, 32'h0006_0000);
      chk({30'h0, clk2_en_q, clk1_en_q}, 32'h3);
      cfg_acc(0, 8'h58, 4'hf, 0, 32'h0000_0001);
      cfg_acc(0, 8'h00, 4'hf, 0, 0);
      $display("test reset_values done");
      for (int i = 0; i < 4; i++) begin
         cfg_acc(1, OFFS[i], 4'hf, 32'hffff_ffff, 0);
         cfg_acc(0, OFFS[i], 4'hf, 0, (i == 2) ? PWR_MASK : WIDE_MASK);
      end
      cfg_acc(1, 8'h58, 4'hf, 32'hffff_ffff, 0);
      cfg_acc(0, 8'h58, 4'hf, 0, 32'hffff_ffff);
      cfg_acc(1, 8'h50, 4'hf, 32'hffff_ffff, 0);
      cfg_acc(0, 8'h50, 4'hf, 0, 0);
      $display("test field_masks done");
      for (int i = 0; i < 4; i++) cfg_acc(1, OFFS[i], 4'hf, BASES[i], 0);
      for (int i = 0; i < 12; i++) io_chk(IO_A[i], IO_E[i]);
      // top lane only: clears the enable, base stays
      for (int i = 0; i < 4; i++) begin
         cfg_acc(1, OFFS[i], 4'h8, 0, 0);
         cfg_acc(0, OFFS[i], 4'hf, 0, BASES[i] & 32'h7fff_ffff);
      end
      for (int i = 0; i < 12; i++) io_chk(IO_A[i], 4'h0);
      $display("test window_decode done");
      cfg_acc(1, 8'h54, 4'h4, 32'h0002_0000, 0);
      chk({30'h0, clk2_en_q, clk1_en_q}, 32'h1);
      cfg_acc(0, 8'h54, 4'hf, 0, 32'h0002_0000);
      cfg_acc(1, 8'h54, 4'h0, 0, 0);
      cfg_acc(0, 8'h54, 4'hf, 0, 32'h0002_0000);
      cfg_acc(1, 8'h54, 4'hf, 32'h0004_0000, 0);
      chk({30'h0, clk2_en_q, clk1_en_q}, 32'h2);
      $display("test clock_gating done");
      // ce low: a pending write must neither land nor be answered
      @(posedge core_clk);
      ce        <= 1'b0;
      cfg_req   <= 1'b1;
      cfg_we    <= 1'b1;
      cfg_addr  <= 8'h54;
      cfg_be    <= 4'hf;
      cfg_wdata <= 32'h0000_0000;
      repeat (2) @(posedge core_clk);
      #1;
      chk({31'h0, cfg_ack_q}, 32'h0);
      chk({30'h0, clk2_en_q, clk1_en_q}, 32'h2);
      @(posedge core_clk);
      ce      <= 1'b1;
      cfg_req <= 1'b0;
      cfg_acc(0, 8'h54, 4'hf, 0, 32'h0004_0000);
      $display("test clock_enable done");
      complete_run;
   end
endmodule

`default_nettype wire
